// File: hw/refsel_pkg.sv
// package for the reference source selector: register indices, field
// positions, reset values, state codes and timing constants.
// assumes a 25 MHz system clock and a 32-bit apb register port.
package refsel_pkg;

  // input count and widths
  localparam int NUM_INPUTS = 14;
  localparam int NUM_PRIO_REGS = 7;
  localparam int ADDR_W = 12;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_INT_STATUS = 8'h06;
  localparam logic [7:0] IDX_OP_STATE = 8'h09;
  localparam logic [7:0] IDX_FORCE_SEL = 8'h33;
  localparam logic [7:0] IDX_NOM_CAL_LO = 8'h3c;
  localparam logic [7:0] IDX_NOM_CAL_HI = 8'h3d;
  localparam logic [7:0] IDX_TOL_34 = 8'h41;
  localparam logic [7:0] IDX_TOL_56 = 8'h42;
  localparam logic [7:0] IDX_MON_CFG = 8'h48;
  localparam logic [7:0] IDX_PRIO_BASE = 8'h18;
  localparam logic [7:0] IDX_MODE_CTRL = 8'h50;
  localparam logic [7:0] IDX_SEL_STATUS = 8'h51;

  // field positions
  localparam int INT_MAIN_REF_FAILED_BIT = 6;
  localparam int MON_EXT_SWITCH_BIT = 4;
  localparam int MON_ULTRA_FAST_BIT = 5;
  localparam int MON_FLAG_TDO_BIT = 6;
  localparam int MODE_REVERTIVE_BIT = 0;
  localparam int MODE_FORCED_CTRL_BIT = 1;
  localparam int MODE_CMD_STATE_LSB = 2;
  localparam int SEL_VALID_BIT = 7;

  // reset values
  localparam logic [7:0] FORCE_SEL_RESET = 8'h0f;
  localparam logic [7:0] MON_CFG_RESET = 8'h00;
  localparam logic [7:0] MODE_CTRL_RESET = 8'h01;
  localparam logic [7:0] PRIO_RESET = 8'h00;
  localparam logic [15:0] NOM_CAL_RESET = 16'h0000;
  // tolerance in steps of 0.4 ppm: 23 is 9.2 ppm, 200 is 80 ppm
  localparam logic [7:0] TOL_NORMAL = 8'h17;
  localparam logic [7:0] TOL_WIDE = 8'hc8;

  // operating state codes reported in bits [2:0]
  localparam logic [2:0] CODE_FREE_RUN = 3'h1;
  localparam logic [2:0] CODE_HOLDOVER = 3'h2;
  localparam logic [2:0] CODE_LOCKED = 3'h4;
  localparam logic [2:0] CODE_PRE_LOCKED2 = 3'h5;
  localparam logic [2:0] CODE_PRE_LOCKED = 3'h6;
  localparam logic [2:0] CODE_LOST_PHASE = 3'h7;

  // operating states
  typedef enum logic [2:0] {
    ST_FREE_RUN, ST_PRE_LOCKED, ST_LOCKED, ST_LOST_PHASE, ST_HOLDOVER, ST_PRE_LOCKED2
  } op_state_t;

  // timing: a 1 ms tick paces all long waits
  localparam int CLK_FREQ_HZ = 25_000_000;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES = CLK_FREQ_HZ / 1_000_000 * TICK_PERIOD_US;
  localparam int LOCK_HOLD_S = 1;
  localparam int LOCK_HOLD_TICKS = LOCK_HOLD_S * 1_000_000 / TICK_PERIOD_US;
  localparam int LOCK_TIMEOUT_S = 100;
  localparam int LOCK_TIMEOUT_TICKS = LOCK_TIMEOUT_S * 1000 * (1000 / TICK_PERIOD_US);
  localparam int STRAP_HOLD_MS = 251;
  localparam int STRAP_HOLD_TICKS = STRAP_HOLD_MS * 1000 / TICK_PERIOD_US;

endpackage

// File: hw/reference_source_selector.sv
// reference source selector: priority / forced / external-pin choice of the
// dpll reference, plus the operating-state machine and its apb registers.
// assumes input validity and fast activity-loss flags from monitors on pclk.
//
// Functional notes
// - non-revertive keeps valid current reference
// - failed current reference always switches away; forced and pin-protection selections keep it
// - force field 0 or 15 auto, else input n
// - force field resets to all ones
// - 4-bit priorities, two per register, seven registers
// - lower value wins; zero excludes input
// - equal priorities served first in, first out
// - revertive setting ignores equal priorities
// - ultra-fast loss sets alarm and switches
// - alarm bit mirrored on test output when enabled
// - test output high until alarm cleared
// - pin strap or control bit enables protection
// - pin high picks three/five, low four/six
// - pin strap widens switched tolerances to 80 ppm
// - zero priority swaps three for five, four for six
// - protection disables monitors, reports locked
// - automatic state control after reset, forced optional
// - free-run uses oscillator plus calibration value
// - free-run to pre-locked on selection
// - no lock in 100 s: free-run, reselect
// - locked entered once reference selected and locked
// - lock counts after one second continuous
// - revertive switches to better validated input
//
// Local design decision: the APB slave port.
module reference_source_selector #(
  parameter int TICK_CYCLES_P = refsel_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [refsel_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // monitor and pll status
  input wire logic [refsel_pkg::NUM_INPUTS-1:0] ref_valid,
  input wire logic [refsel_pkg::NUM_INPUTS-1:0] ref_activity_lost,
  input wire logic pll_phase_locked,
  // external protection pin
  input wire logic protection_switch_pin,
  // selection to the dpll
  output logic [3:0] selected_ref,
  output logic ref_selected,
  output logic pll_force_ref,
  output logic monitors_disabled,
  output logic [2:0] op_state_code,
  output logic freerun_active,
  output logic [15:0] nominal_freq_cal,
  output logic [7:0] tol_34,
  output logic [7:0] tol_56,
  // test data output flag pin
  output logic tdo_flag_out,
  output logic tdo_flag_oe
);
  import refsel_pkg::*;

  // register file
  logic [7:0] force_sel_reg;
  logic [7:0] mon_cfg_reg;
  logic [7:0] mode_ctrl_reg;
  logic [7:0] prio_reg [NUM_PRIO_REGS];
  logic [15:0] nom_cal_reg;
  logic [7:0] tol_34_reg;
  logic [7:0] tol_56_reg;
  logic tol_written_reg; // software or the strap has set a tolerance
  logic main_ref_failed_reg; // sticky alarm
  // selection state
  logic [3:0] cur_idx_reg; // index of current reference
  logic have_ref_reg; // a reference is selected
  logic [NUM_INPUTS-1:0] rejected_reg; // disqualified until re-validated
  logic [NUM_INPUTS-1:0] valid_prev_reg;
  logic [7:0] stamp_reg [NUM_INPUTS]; // arrival order stamps
  logic [7:0] seq_reg;
  // pin synchroniser and strap capture
  logic pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_level_reg;
  logic strap_done_reg, strap_en_reg;
  logic [15:0] strap_cnt_reg;
  // timing
  logic [31:0] tick_cnt_reg;
  logic tick_reg;
  logic [19:0] lock_cnt_reg;
  logic [19:0] timeout_cnt_reg;
  op_state_t state_reg, state_next;
  // apb handshake
  logic pready_reg;

  // bus decode helpers
  logic access;
  logic wr_en;
  logic [7:0] idx;
  assign access = psel & penable & pready_reg;
  assign wr_en = access & pwrite;
  assign idx = paddr[9:2];

  // priority of input i (input number i+1), two nibbles per register
  function automatic logic [3:0] prio_of(input logic [3:0] i);
    logic [7:0] r;
    r = prio_reg[i[3:1]];
    return i[0] ? r[7:4] : r[3:0];
  endfunction

  // force field decode: zero or all ones mean automatic
  function automatic logic is_auto(input logic [3:0] f);
    return (f == 4'h0) || (f == 4'hf);
  endfunction

  // register is one of the seven priority registers
  function automatic logic is_prio(input logic [7:0] a);
    return (a >= IDX_PRIO_BASE) && (a < IDX_PRIO_BASE + 8'(NUM_PRIO_REGS));
  endfunction

  // map a commanded state code onto the state machine
  function automatic op_state_t code_to_state(input logic [2:0] c, input op_state_t d);
    case (c)
      CODE_FREE_RUN: return ST_FREE_RUN;
      CODE_HOLDOVER: return ST_HOLDOVER;
      CODE_LOCKED: return ST_LOCKED;
      CODE_PRE_LOCKED2: return ST_PRE_LOCKED2;
      CODE_PRE_LOCKED: return ST_PRE_LOCKED;
      CODE_LOST_PHASE: return ST_LOST_PHASE;
      default: return d;
    endcase
  endfunction

  // configuration shortcuts
  logic ext_mode, ultra_fast, revertive;
  assign ext_mode = mon_cfg_reg[MON_EXT_SWITCH_BIT] | strap_en_reg;
  assign ultra_fast = mon_cfg_reg[MON_ULTRA_FAST_BIT];
  assign revertive = mode_ctrl_reg[MODE_REVERTIVE_BIT];

  // eligibility per input
  logic [NUM_INPUTS-1:0] eligible;
  for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_elig
    assign eligible[g] = ref_valid[g] & (prio_of(4'(g)) != 4'h0) & ~rejected_reg[g];
  end

  // best candidate: lowest priority value, then oldest arrival
  logic best_found;
  logic [3:0] best_idx, best_prio;
  logic [7:0] best_age;
  always_comb begin
    logic [7:0] age;
    age = 8'h00;
    best_found = 1'b0;
    best_idx = 4'h0;
    best_prio = 4'hf;
    best_age = 8'h00;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      age = seq_reg - stamp_reg[i];
      if (eligible[i]) begin
        // lower value wins; ties go to the longest waiting
        if (!best_found || prio_of(4'(i)) < best_prio ||
            (prio_of(4'(i)) == best_prio && age > best_age)) begin
          best_found = 1'b1;
          best_idx = 4'(i);
          best_prio = prio_of(4'(i));
          best_age = age;
        end
      end
    end
  end

  // current reference health
  logic fast_fail, cur_ok, timeout_hit;
  assign fast_fail = have_ref_reg & ultra_fast & ref_activity_lost[cur_idx_reg];
  assign cur_ok = have_ref_reg & eligible[cur_idx_reg] & ~fast_fail & ~timeout_hit;
  assign timeout_hit = tick_reg && (timeout_cnt_reg >= 20'(LOCK_TIMEOUT_TICKS - 1)) &&
                       (state_reg == ST_PRE_LOCKED || state_reg == ST_PRE_LOCKED2 ||
                        state_reg == ST_LOST_PHASE);

  // next selection
  logic [3:0] sel_next;
  logic have_next;
  always_comb begin
    sel_next = cur_idx_reg;
    have_next = have_ref_reg;
    if (ext_mode) begin
      // pin chooses the pair, a zero priority swaps in the spare
      have_next = 1'b1;
      if (pin_level_reg) begin
        sel_next = (prio_of(4'd2) == 4'h0) ? 4'd4 : 4'd2;
      end else begin
        sel_next = (prio_of(4'd3) == 4'h0) ? 4'd5 : 4'd3;
      end
    end else if (!is_auto(force_sel_reg[3:0])) begin
      // forced input n
      have_next = 1'b1;
      sel_next = force_sel_reg[3:0] - 4'd1;
    end else if (!cur_ok) begin
      // current gone: take the best left, or nothing
      have_next = best_found;
      sel_next = best_found ? best_idx : cur_idx_reg;
    end else if (revertive && best_found && best_prio < prio_of(cur_idx_reg)) begin
      // strictly better only; equal values never pre-empt
      sel_next = best_idx;
    end
    // otherwise non-revertive holds a still-valid reference
  end

  logic sel_change;
  assign sel_change = (have_next != have_ref_reg) || (have_next && sel_next != cur_idx_reg);

  // selection registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_idx_reg <= 4'h0;
      have_ref_reg <= 1'b0;
    end else begin
      cur_idx_reg <= sel_next;
      have_ref_reg <= have_next;
    end
  end

  // arrival stamps: a newly valid input joins the back of its queue
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_prev_reg <= '0;
      seq_reg <= 8'h00;
      for (int i = 0; i < NUM_INPUTS; i++) begin
        stamp_reg[i] <= 8'h00;
      end
    end else begin
      valid_prev_reg <= ref_valid;
      if (|(ref_valid & ~valid_prev_reg)) begin
        seq_reg <= seq_reg + 8'h01;
      end
      for (int i = 0; i < NUM_INPUTS; i++) begin
        if (ref_valid[i] && !valid_prev_reg[i]) begin
          stamp_reg[i] <= seq_reg;
        end
      end
    end
  end

  // disqualification of a failed current reference; a new failure beats the acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rejected_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        if (have_ref_reg && cur_idx_reg == 4'(i) && !ext_mode &&
            (fast_fail || timeout_hit)) begin
          rejected_reg[i] <= 1'b1;
        end else if (!ref_valid[i] || (wr_en && idx == IDX_INT_STATUS)) begin
          rejected_reg[i] <= 1'b0; // dropout or software acknowledge
        end
      end
    end
  end

  // main reference failed alarm, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_ref_failed_reg <= 1'b0;
    end else if (fast_fail && !ext_mode) begin
      main_ref_failed_reg <= 1'b1;
    end else if (wr_en && idx == IDX_INT_STATUS && pwdata[INT_MAIN_REF_FAILED_BIT]) begin
      main_ref_failed_reg <= 1'b0;
    end
  end

  // three-stage pin synchroniser; level taken when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_s3_reg <= 1'b0;
      pin_level_reg <= 1'b0;
    end else begin
      pin_s1_reg <= protection_switch_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      if (pin_s2_reg == pin_s3_reg) begin
        pin_level_reg <= pin_s3_reg;
      end
    end
  end

  // millisecond tick divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 32'h0;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg >= 32'(TICK_CYCLES_P - 1)) begin
      tick_cnt_reg <= 32'h0;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
      tick_reg <= 1'b0;
    end
  end

  // strap: pin high through the hold window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_reg <= 1'b0;
      strap_en_reg <= 1'b0;
      strap_cnt_reg <= 16'h0;
    end else if (!strap_done_reg) begin
      if (tick_reg && !pin_level_reg) begin
        strap_done_reg <= 1'b1; // pin dropped early: no strap
      end else if (tick_reg && strap_cnt_reg >= 16'(STRAP_HOLD_TICKS - 1)) begin
        strap_done_reg <= 1'b1;
        strap_en_reg <= 1'b1;
      end else if (tick_reg) begin
        strap_cnt_reg <= strap_cnt_reg + 16'h1;
      end
    end
  end

  // continuous phase lock qualifier
  logic pll_locked;
  assign pll_locked = lock_cnt_reg >= 20'(LOCK_HOLD_TICKS);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt_reg <= 20'h0;
    end else if (!pll_phase_locked || sel_change) begin
      lock_cnt_reg <= 20'h0;
    end else if (tick_reg && !pll_locked) begin
      lock_cnt_reg <= lock_cnt_reg + 20'h1;
    end
  end

  // acquisition timeout, restarted on each state or reference change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_cnt_reg <= 20'h0;
    end else if (state_next != state_reg || sel_change) begin
      timeout_cnt_reg <= 20'h0;
    end else if (tick_reg) begin
      timeout_cnt_reg <= timeout_cnt_reg + 20'h1;
    end
  end

  // automatic operating-state transitions
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_FREE_RUN: begin
        if (have_ref_reg) state_next = ST_PRE_LOCKED;
      end
      ST_PRE_LOCKED, ST_PRE_LOCKED2: begin
        if (timeout_hit || !have_ref_reg) begin
          state_next = ST_FREE_RUN;
        end else if (pll_locked) begin
          state_next = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        if (!have_next) begin
          state_next = ST_HOLDOVER;
        end else if (sel_change) begin
          state_next = ST_PRE_LOCKED2;
        end else if (!pll_phase_locked) begin
          state_next = ST_LOST_PHASE;
        end
      end
      ST_LOST_PHASE: begin
        if (timeout_hit || !have_ref_reg) begin
          state_next = have_next ? ST_PRE_LOCKED2 : ST_HOLDOVER;
        end else if (pll_locked) begin
          state_next = ST_LOCKED;
        end
      end
      ST_HOLDOVER: begin
        if (have_ref_reg) state_next = ST_PRE_LOCKED2;
      end
      default: state_next = ST_FREE_RUN;
    endcase
  end

  // state register: automatic unless forced control is configured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_FREE_RUN;
    end else if (mode_ctrl_reg[MODE_FORCED_CTRL_BIT]) begin
      state_reg <= code_to_state(mode_ctrl_reg[MODE_CMD_STATE_LSB +: 3], state_reg);
    end else begin
      state_reg <= state_next;
    end
  end

  // reported state code; protection mode always reads locked
  logic [2:0] code_now;
  always_comb begin
    case (state_reg)
      ST_FREE_RUN: code_now = CODE_FREE_RUN;
      ST_PRE_LOCKED: code_now = CODE_PRE_LOCKED;
      ST_LOCKED: code_now = CODE_LOCKED;
      ST_LOST_PHASE: code_now = CODE_LOST_PHASE;
      ST_HOLDOVER: code_now = CODE_HOLDOVER;
      ST_PRE_LOCKED2: code_now = CODE_PRE_LOCKED2;
      default: code_now = CODE_FREE_RUN;
    endcase
    if (ext_mode) code_now = CODE_LOCKED;
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_sel_reg <= FORCE_SEL_RESET;
      mon_cfg_reg <= MON_CFG_RESET;
      mode_ctrl_reg <= MODE_CTRL_RESET;
      nom_cal_reg <= NOM_CAL_RESET;
      for (int i = 0; i < NUM_PRIO_REGS; i++) begin
        prio_reg[i] <= PRIO_RESET;
      end
    end else if (wr_en) begin
      case (idx)
        IDX_FORCE_SEL: force_sel_reg <= pwdata[7:0];
        IDX_MON_CFG: mon_cfg_reg <= pwdata[7:0];
        IDX_MODE_CTRL: mode_ctrl_reg <= pwdata[7:0];
        IDX_NOM_CAL_LO: nom_cal_reg[7:0] <= pwdata[7:0];
        IDX_NOM_CAL_HI: nom_cal_reg[15:8] <= pwdata[7:0];
        default: begin
          if (is_prio(idx)) prio_reg[3'(idx - IDX_PRIO_BASE)] <= pwdata[7:0];
        end
      endcase
    end
  end

  // tolerances: pin strap widens defaults unless software got there first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tol_34_reg <= TOL_NORMAL;
      tol_56_reg <= TOL_NORMAL;
      tol_written_reg <= 1'b0;
    end else if (wr_en && idx == IDX_TOL_34) begin
      tol_34_reg <= pwdata[7:0];
      tol_written_reg <= 1'b1;
    end else if (wr_en && idx == IDX_TOL_56) begin
      tol_56_reg <= pwdata[7:0];
      tol_written_reg <= 1'b1;
    end else if (strap_en_reg && !tol_written_reg) begin
      tol_34_reg <= TOL_WIDE;
      tol_56_reg <= TOL_WIDE;
      tol_written_reg <= 1'b1;
    end
  end

  // read mux
  logic [7:0] rd_val;
  logic mapped;
  always_comb begin
    rd_val = 8'h00;
    mapped = 1'b1;
    case (idx)
      IDX_INT_STATUS: rd_val = 8'(main_ref_failed_reg) << INT_MAIN_REF_FAILED_BIT;
      IDX_OP_STATE: rd_val = {5'h00, code_now};
      IDX_FORCE_SEL: rd_val = force_sel_reg;
      IDX_NOM_CAL_LO: rd_val = nom_cal_reg[7:0];
      IDX_NOM_CAL_HI: rd_val = nom_cal_reg[15:8];
      IDX_TOL_34: rd_val = tol_34_reg;
      IDX_TOL_56: rd_val = tol_56_reg;
      IDX_MON_CFG: rd_val = mon_cfg_reg;
      IDX_MODE_CTRL: rd_val = mode_ctrl_reg;
      IDX_SEL_STATUS: rd_val = {have_ref_reg, 3'h0, have_ref_reg ? cur_idx_reg + 4'd1 : 4'h0};
      default: begin
        if (is_prio(idx)) begin
          rd_val = prio_reg[3'(idx - IDX_PRIO_BASE)];
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
    if (paddr[1:0] != 2'b00 || paddr[ADDR_W-1:10] != '0) mapped = 1'b0;
  end

  // apb answer: no wait state, data and error latched in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable && !pready_reg) begin
      pready_reg <= 1'b1;
      prdata <= pwrite ? 32'h0 : {24'h0, rd_val};
      pslverr <= ~mapped;
    end else begin
      pready_reg <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
  end
  assign pready = pready_reg;

  // registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      selected_ref <= 4'h0;
      ref_selected <= 1'b0;
      pll_force_ref <= 1'b0;
      monitors_disabled <= 1'b0;
      op_state_code <= CODE_FREE_RUN;
      freerun_active <= 1'b1;
      nominal_freq_cal <= NOM_CAL_RESET;
      tol_34 <= TOL_NORMAL;
      tol_56 <= TOL_NORMAL;
      tdo_flag_out <= 1'b0;
      tdo_flag_oe <= 1'b0;
    end else begin
      selected_ref <= have_ref_reg ? cur_idx_reg + 4'd1 : 4'h0;
      ref_selected <= have_ref_reg;
      pll_force_ref <= ext_mode;
      monitors_disabled <= ext_mode;
      op_state_code <= code_now;
      freerun_active <= (state_reg == ST_FREE_RUN) && !ext_mode;
      nominal_freq_cal <= nom_cal_reg;
      tol_34 <= tol_34_reg;
      tol_56 <= tol_56_reg;
      tdo_flag_out <= mon_cfg_reg[MON_FLAG_TDO_BIT] & main_ref_failed_reg;
      tdo_flag_oe <= mon_cfg_reg[MON_FLAG_TDO_BIT];
    end
  end

endmodule

// File: tb/ref_sources.sv
// far-side model: reference sources, phase detector and protection pin
// assumes the bench commands it and it updates on the pclk rising edge
module ref_sources (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // commands from the bench
  input wire logic [13:0] src_up,
  input wire logic lock_up,
  input wire logic pin_level,
  // toward the selector
  output logic [13:0] ref_valid,
  output logic [13:0] ref_activity_lost,
  output logic pll_phase_locked,
  output logic protection_switch_pin
);
  logic [13:0] up_reg; // sources present last cycle
  // a stopping source shows one cycle of activity loss
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_reg <= '0;
      ref_valid <= '0;
      ref_activity_lost <= '0;
    end else begin
      up_reg <= src_up;
      ref_valid <= up_reg & src_up;
      ref_activity_lost <= up_reg & ~src_up;
    end
  end
  // pin held by the far party
  assign protection_switch_pin = pin_level;
  assign pll_phase_locked = lock_up;
endmodule

// File: tb/refsel_sva.sv
// port checker for the reference source selector
// assumes a bind onto the design top, single pclk domain
module refsel_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic protection_switch_pin,
  input wire logic [3:0] selected_ref,
  input wire logic ref_selected,
  input wire logic pll_force_ref,
  input wire logic monitors_disabled,
  input wire logic [2:0] op_state_code,
  input wire logic freerun_active,
  input wire logic tdo_flag_out,
  input wire logic tdo_flag_oe
);
  import refsel_pkg::*;
  logic [1:0] wr_h; // recent write cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_h <= 2'b00;
    else wr_h <= {wr_h[0], psel && pwrite};
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_once: assert property (pready |=> !pready) else $error("pready too long");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_sel_flag: assert property (ref_selected == (selected_ref != 4'h0))
    else $error("select flag wrong");
  a_tdo_enable: assert property (tdo_flag_out |-> tdo_flag_oe) else $error("tdo off");
  a_tdo_holds: assert property (tdo_flag_out && !(psel && pwrite) && wr_h == 2'b00
    |=> tdo_flag_out) else $error("tdo dropped");
  a_prot_locked: assert property (pll_force_ref [*3]
    |-> op_state_code == CODE_LOCKED && monitors_disabled) else $error("protection state");
  a_free_code: assert property (freerun_active |-> op_state_code == CODE_FREE_RUN)
    else $error("free-run code");
  a_pin_high: assert property ((pll_force_ref && protection_switch_pin) [*8]
    |-> selected_ref inside {4'h3, 4'h5}) else $error("pin high pick");
  a_pin_low: assert property ((pll_force_ref && !protection_switch_pin) [*8]
    |-> selected_ref inside {4'h4, 4'h6}) else $error("pin low pick");
  a_lock_ref: assert property ($rose(op_state_code == CODE_LOCKED) && !pll_force_ref
    |-> ref_selected) else $error("locked without reference");
endmodule
bind reference_source_selector refsel_sva u_sva (.*);

// File: tb/tb_top.sv
// bench for the reference source selector over apb
// assumes a 40 ns pclk; tick shortened to 4 cycles
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import refsel_pkg::*;
  localparam int TK = 4;
  logic pclk, presetn, psel, penable, pwrite, lock_up, pin_level, pready, pslverr, rerr;
  logic ref_selected, tdo_flag_out, pll_phase_locked, protection_switch_pin, pll_force_ref;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [13:0] src_up, ref_valid, ref_activity_lost;
  logic [3:0] selected_ref;
  logic [2:0] op_state_code;
  logic [15:0] cal;
  logic [7:0] ri[4] = '{IDX_FORCE_SEL, IDX_MON_CFG, IDX_OP_STATE, IDX_TOL_34};
  logic [7:0] rv[4] = '{FORCE_SEL_RESET, MON_CFG_RESET, 8'h01, TOL_NORMAL};
  int n_errors, n_tests;
  reference_source_selector #(.TICK_CYCLES_P(TK)) dut (.pclk, .presetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .ref_valid, .ref_activity_lost,
    .pll_phase_locked, .protection_switch_pin, .selected_ref, .ref_selected, .pll_force_ref,
    .monitors_disabled(), .op_state_code, .freerun_active(), .nominal_freq_cal(cal), .tol_34(),
    .tol_56(), .tdo_flag_out, .tdo_flag_oe());
  ref_sources far (.pclk, .presetn, .src_up, .lock_up, .pin_level, .ref_valid,
    .ref_activity_lost, .pll_phase_locked, .protection_switch_pin);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic step(input logic [13:0] s);
    src_up <= s;
    settle(10);
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    settle(20000);
    n_errors++;
    complete_run();
  end
  initial begin
    {n_errors, n_tests, psel, penable, pwrite, paddr, pwdata} = '0;
    {src_up, lock_up, pin_level, presetn} = '0;
    settle(2);
    presetn <= 1'b1;
    foreach (ri[i]) begin
      apb(1'b0, ri[i], 8'h00);
      chk(rdat, {24'h0, rv[i]}, "reset value");
    end
    apb(1'b0, 8'h7f, 8'h00);
    chk(rerr, 1, "unmapped error");
    apb(1'b1, IDX_NOM_CAL_LO, 8'h5a);
    apb(1'b1, IDX_PRIO_BASE, 8'h21);
    apb(1'b1, IDX_PRIO_BASE + 8'h01, 8'h03);
    apb(1'b1, IDX_MODE_CTRL, 8'h00);
    chk(cal, 16'h005a, "calibration");
    step(14'h000f);
    chk(selected_ref, 1, "best input");
    chk(op_state_code, CODE_PRE_LOCKED, "state");
    step(14'h000e);
    chk(selected_ref, 2, "after failure");
    step(14'h000f);
    chk(selected_ref, 2, "non-revertive");
    apb(1'b1, IDX_MODE_CTRL, 8'h01);
    settle(10);
    chk(selected_ref, 1, "revertive");
    step(14'h0008);
    chk(ref_selected, 0, "excluded only");
    apb(1'b1, IDX_PRIO_BASE, 8'h11);
    step(14'h0002);
    step(14'h0003);
    chk(selected_ref, 2, "first in");
    step(14'h0001);
    step(14'h0003);
    chk(selected_ref, 1, "no switch on return");
    apb(1'b1, IDX_FORCE_SEL, 8'h05);
    settle(10);
    chk(selected_ref, 5, "forced");
    apb(1'b1, IDX_FORCE_SEL, 8'h00);
    settle(10);
    chk(selected_ref, 1, "automatic");
    lock_up <= 1'b1;
    settle(LOCK_HOLD_TICKS * TK - 200);
    chk(op_state_code == CODE_LOCKED, 0, "early lock");
    settle(400);
    chk(op_state_code, CODE_LOCKED, "locked");
    apb(1'b1, IDX_MON_CFG, 8'h60);
    src_up <= 14'h0002;
    settle(10);
    chk(tdo_flag_out, 1, "test flag");
    chk(selected_ref, 2, "fast switch");
    apb(1'b1, IDX_INT_STATUS, 8'h40);
    settle(4);
    chk(tdo_flag_out, 0, "flag cleared");
    apb(1'b1, IDX_MON_CFG, 8'h10);
    pin_level <= 1'b1;
    settle(12);
    chk(selected_ref, 3, "pin high");
    chk(op_state_code, CODE_LOCKED, "protect state");
    pin_level <= 1'b0;
    settle(12);
    chk(selected_ref, 6, "pin low");
    apb(1'b1, IDX_PRIO_BASE + 8'h01, 8'h00);
    pin_level <= 1'b1;
    settle(12);
    chk(selected_ref, 5, "swap to five");
    presetn <= 1'b0;
    settle(2);
    presetn <= 1'b1;
    settle(STRAP_HOLD_TICKS * TK + 100);
    chk(pll_force_ref, 1, "strap");
    apb(1'b0, IDX_TOL_34, 8'h00);
    chk(rdat, {24'h0, TOL_WIDE}, "wide tolerance");
    complete_run();
  end
endmodule
